// File: hw/tamper_pulse_pkg.sv
// Purpose: constants and types for tamper channel selection and energy pulses
// Assumes: 24-bit fixed point, full scale 1.0 = 2^23, output word rate tick input
// Notes:   register map below is the software view of the block
// Contract
// R1: In line-neutral mode pick the channel with greater magnitude for totals.
// R2: Compare power averages when compare-source is 0, RMS currents otherwise.
// R3: Automatic choice acts only while a channel exceeds the minimum amplitude.
// R4: Switch only when inactive magnitude exceeds active magnitude times level factor.
// R5: Keep selection when active merely drops below the other channel.
// R6: Automatic selection is on by default after reset.
// R7: Hold bit stops automatic choice; force bit names the channel.
// R8: Fixed-voltage bit substitutes reference voltage in the active power path only.
// R9: Fixed voltage reference resets to 0.707107 and is host writable.
// R10: Three independent generators, any can reach any of three pins.
// R11: Pulse frequency is proportional to selected power magnitude.
// R12: After reset generators are disabled and every pin mode is high impedance.
// R13: Open-drain bit set drives open-drain, clear drives push-pull.
// R14: Per-generator 4-bit input select in pulse control chooses power result.
// R15: Host sets generator enable and pin mode to see pulses.
// R16: Full-scale frequency equals rate times 2000 over two to the range.
// R17: Host programs frequency range to 0110 before the pulse rate.
// R18: Pulse low time is 250 us plus width over 64000 seconds.
// R19: Pulse width register resets to 1, giving 265.6 us low time.
// R20: Host keeps pulse low time below the pulse period.
// R21: Channel selection applies only when meter configuration field is 00.
// R22: Accumulate scaled magnitude each word interval, pulse on each full unit.
// R23: Under hold, force clear uses channel one, set uses channel two.
package tamper_pulse_pkg;
    localparam int DATA_W         = 24;
    localparam int ADDR_W         = 4;
    localparam int NUM_GEN        = 3;
    localparam int SEL_W          = 4;
    localparam int ACC_W          = 48;
    localparam int LEVEL_FRAC     = 22;

    localparam logic [ADDR_W-1:0] ADDR_METER_CFG  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OUTPUT_CFG = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PULSE_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PULSE_RATE = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_PULSE_WID  = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_SEL_MIN    = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_SEL_LEVEL  = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_FIXED_VOLTAGE_ENABLE_REF   = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = 4'h8;

    // Meter configuration register fields
    localparam int METER_CONFIGURATION_FIELD_LSB = 0;
    localparam int CMP_BIT  = 2;
    localparam int HOLD_BIT = 3;
    localparam int FORCE_BIT = 4;
    localparam int FIXED_VOLTAGE_ENABLE_BIT = 5;
    localparam logic [1:0] LINE_NEUTRAL_MODE = 2'h0;
    // Output config: mode nibbles at 0, open drain bits at OD_LSB
    localparam int OD_LSB = 12;
    localparam logic [SEL_W-1:0] MODE_HIZ  = 4'h0;
    localparam logic [SEL_W-1:0] MODE_GEN1 = 4'h1;
    // Pulse control: input nibbles at 0, enables at EN_LSB
    localparam int EN_LSB = 12;
    // Pulse width register: width at 0, range field at RNG_LSB
    localparam int WIDTH_W = 16;
    localparam int RNG_LSB = 16;

    localparam logic [DATA_W-1:0] METER_CFG_RST  = 24'h000000;
    localparam logic [DATA_W-1:0] OUTPUT_CFG_RST = 24'h000000;
    localparam logic [DATA_W-1:0] PULSE_CTRL_RST = 24'h000000;
    localparam logic [DATA_W-1:0] PULSE_RATE_RST = 24'h000000;
    localparam logic [DATA_W-1:0] PULSE_WID_RST  = 24'h000001;
    localparam logic [DATA_W-1:0] SEL_MIN_RST    = 24'h000000;
    localparam logic [DATA_W-1:0] SEL_LEVEL_RST  = 24'h400000;
    localparam logic [DATA_W-1:0] FIXED_VOLTAGE_ENABLE_REF_RST   = 24'h5A827A;

    localparam int CLK_HZ          = 125_000_000;
    localparam int CLK_PERIOD_NS   = 8;
    localparam int PULSE_BASE_NS   = 250_000;
    localparam int PULSE_BASE_CYC  = (PULSE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WIDTH_DIV_HZ    = 64000;
    localparam int WIDTH_FRAC      = 3;
    // Scale before dividing so the fraction of clock over 64000 is kept
    localparam int WIDTH_CYC_SCALED = CLK_HZ * (1 << WIDTH_FRAC) / WIDTH_DIV_HZ;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;
endpackage : tamper_pulse_pkg

// File: hw/tamper_pulse_core.sv
// Purpose: tamper channel selection, fixed voltage mux and three pulse generators
// Assumes: owr_tick is a one-cycle pulse per output word, same clock domain
// Notes:   pins are split into out/enable; low level marks an energy pulse
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
module tamper_pulse_core
    import tamper_pulse_pkg::*;
#(
    parameter int NUM_RESULTS      = 16,
    parameter int PULSE_BASE_CYC_P = PULSE_BASE_CYC
) (
    input  wire logic                                  core_clk,
    input  wire logic                                  sys_rst,
    input  wire reg_req_t                              reg_req,
    output logic [DATA_W-1:0]                          reg_rdata,
    input  wire logic                                  owr_tick,
    input  wire logic [1:0][DATA_W-1:0]                channel_power_average,
    input  wire logic [1:0][DATA_W-1:0]                channel_current_rms,
    input  wire logic [DATA_W-1:0]                     measured_voltage_rms,
    input  wire logic [NUM_RESULTS-1:0][DATA_W-1:0]    power_result,
    output logic                                       total_channel_select,
    output logic                                       auto_select_active,
    output logic [DATA_W-1:0]                          active_voltage,
    output logic [NUM_GEN-1:0]                         digital_output_pin,
    output logic [NUM_GEN-1:0]                         digital_output_pin_oe
);
    // Two's complement magnitude; most negative code maps to full scale
    function automatic logic [DATA_W-1:0] magnitude(input logic [DATA_W-1:0] v);
        magnitude = v[DATA_W-1] ? (~v + 24'h000001) : v;
    endfunction : magnitude

    logic [DATA_W-1:0] meter_config_register,  meter_cfg_next;
    logic [DATA_W-1:0] output_config_register, output_cfg_next;
    logic [DATA_W-1:0] pulse_control_register, pulse_ctrl_next;
    logic [DATA_W-1:0] pulse_rate_register,    pulse_rate_next;
    logic [DATA_W-1:0] pulse_width_register,   pulse_width_next;
    logic [DATA_W-1:0] select_min_current,     select_min_next;
    logic [DATA_W-1:0] select_level_reg,       select_level_next;
    logic [DATA_W-1:0] fixed_voltage_reference, fixed_voltage_next;
    logic [DATA_W-1:0] rdata_reg,              rdata_next;
    logic              sel_reg,                sel_next;
    logic              region_reg,             region_next;
    logic [DATA_W-1:0] vout_reg,               vout_next;
    logic [NUM_GEN-1:0] pin_reg,               pin_next;
    logic [NUM_GEN-1:0] oe_reg,                oe_next;
    logic [NUM_GEN-1:0] gen_low;

    logic [1:0]        meter_configuration_field;
    logic              select_compare_source;
    logic              channel_hold;
    logic              channel_force;
    logic              fixed_voltage_enable;
    logic [DATA_W-1:0] mag1;
    logic [DATA_W-1:0] mag2;
    logic [DATA_W-1:0] mag_active;
    logic [DATA_W-1:0] mag_other;
    logic              in_region;
    logic              switch_cond;
    logic [31:0]       pulse_low_cycles;

    assign meter_configuration_field                  = meter_config_register[METER_CONFIGURATION_FIELD_LSB +: 2];
    assign select_compare_source = meter_config_register[CMP_BIT];
    assign channel_hold          = meter_config_register[HOLD_BIT];
    assign channel_force         = meter_config_register[FORCE_BIT];
    assign fixed_voltage_enable  = meter_config_register[FIXED_VOLTAGE_ENABLE_BIT];

    // Register file: writes land the cycle after the strobe, reads answer one cycle later
    always_comb begin
        meter_cfg_next     = meter_config_register;
        output_cfg_next    = output_config_register;
        pulse_ctrl_next    = pulse_control_register;
        pulse_rate_next    = pulse_rate_register;
        pulse_width_next   = pulse_width_register;
        select_min_next    = select_min_current;
        select_level_next  = select_level_reg;
        fixed_voltage_next = fixed_voltage_reference;
        rdata_next         = '0;
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_METER_CFG:  meter_cfg_next     = reg_req.wdata;
                ADDR_OUTPUT_CFG: output_cfg_next    = reg_req.wdata;
                ADDR_PULSE_CTRL: pulse_ctrl_next    = reg_req.wdata;
                ADDR_PULSE_RATE: pulse_rate_next    = reg_req.wdata;
                ADDR_PULSE_WID:  pulse_width_next   = reg_req.wdata;
                ADDR_SEL_MIN:    select_min_next    = reg_req.wdata;
                ADDR_SEL_LEVEL:  select_level_next  = reg_req.wdata;
                ADDR_FIXED_VOLTAGE_ENABLE_REF:   fixed_voltage_next = reg_req.wdata; // R9
                default:         ;
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_METER_CFG:  rdata_next = meter_config_register;
                ADDR_OUTPUT_CFG: rdata_next = output_config_register;
                ADDR_PULSE_CTRL: rdata_next = pulse_control_register;
                ADDR_PULSE_RATE: rdata_next = pulse_rate_register;
                ADDR_PULSE_WID:  rdata_next = pulse_width_register;
                ADDR_SEL_MIN:    rdata_next = select_min_current;
                ADDR_SEL_LEVEL:  rdata_next = select_level_reg;
                ADDR_FIXED_VOLTAGE_ENABLE_REF:   rdata_next = fixed_voltage_reference;
                ADDR_STATUS:     rdata_next = {19'h00000, gen_low, region_reg, sel_reg};
                default:         rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meter_config_register   <= METER_CFG_RST;  // R6
            output_config_register  <= OUTPUT_CFG_RST; // R12
            pulse_control_register  <= PULSE_CTRL_RST; // R12
            pulse_rate_register     <= PULSE_RATE_RST;
            pulse_width_register    <= PULSE_WID_RST;  // R19
            select_min_current      <= SEL_MIN_RST;
            select_level_reg        <= SEL_LEVEL_RST;
            fixed_voltage_reference <= FIXED_VOLTAGE_ENABLE_REF_RST;   // R9
            rdata_reg               <= '0;
        end else begin
            meter_config_register   <= meter_cfg_next;
            output_config_register  <= output_cfg_next;
            pulse_control_register  <= pulse_ctrl_next;
            pulse_rate_register     <= pulse_rate_next;
            pulse_width_register    <= pulse_width_next;
            select_min_current      <= select_min_next;
            select_level_reg        <= select_level_next;
            fixed_voltage_reference <= fixed_voltage_next;
            rdata_reg               <= rdata_next;
        end
    end

    // Channel magnitudes and hysteresis compare; level factor has 22 fraction bits
    always_comb begin
        mag1 = select_compare_source ? channel_current_rms[0]
                                     : magnitude(channel_power_average[0]); // R2
        mag2 = select_compare_source ? channel_current_rms[1]
                                     : magnitude(channel_power_average[1]); // R2
        mag_active  = sel_reg ? mag2 : mag1;
        mag_other   = sel_reg ? mag1 : mag2;
        in_region   = (mag1 > select_min_current) || (mag2 > select_min_current); // R3
        switch_cond = {2'b00, mag_other, {LEVEL_FRAC{1'b0}}}
                      > (ACC_W'(mag_active) * ACC_W'(select_level_reg)); // R4
    end

    always_comb begin
        sel_next    = sel_reg;
        region_next = region_reg;
        if (owr_tick) begin
            region_next = in_region;
            if (meter_configuration_field != LINE_NEUTRAL_MODE) begin
                sel_next = 1'b0; // R21
            end else if (channel_hold) begin
                sel_next = channel_force; // R7 R23
            end else if (in_region && switch_cond) begin
                sel_next = ~sel_reg; // R1 R4
            end else begin
                sel_next = sel_reg; // R5
            end
        end
        // Reactive and apparent paths keep the measured voltage
        vout_next = fixed_voltage_enable ? fixed_voltage_reference
                                         : measured_voltage_rms; // R8
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_reg    <= 1'b0;
            region_reg <= 1'b0;
            vout_reg   <= '0;
        end else begin
            sel_reg    <= sel_next;
            region_reg <= region_next;
            vout_reg   <= vout_next;
        end
    end

    // Low time in cycles: base plus width scaled by clock over 64000
    assign pulse_low_cycles = 32'(PULSE_BASE_CYC_P)
        + 32'((32'(pulse_width_register[WIDTH_W-1:0]) * 32'(WIDTH_CYC_SCALED)) >> WIDTH_FRAC); // R18

    generate
        for (genvar g = 0; g < NUM_GEN; g++) begin : gen_pulse
            logic [ACC_W-1:0]  acc_reg,  acc_next;
            logic [31:0]       cnt_reg,  cnt_next;
            logic [ACC_W:0]    acc_sum;
            logic [DATA_W-1:0] mag;
            logic [SEL_W-1:0]  in_sel;
            logic [3:0]        rng;
            logic              enabled;

            always_comb begin
                in_sel  = pulse_control_register[g*SEL_W +: SEL_W]; // R14
                enabled = pulse_control_register[EN_LSB + g];
                rng     = pulse_width_register[RNG_LSB +: 4];
                mag     = (32'(in_sel) < NUM_RESULTS)
                          ? magnitude(power_result[in_sel]) : '0;
                // One full unit is 2^47; increment per word is |P|*rate/2^range
                acc_sum = {1'b0, acc_reg}
                          + ((ACC_W+1)'(ACC_W'(mag) * ACC_W'(pulse_rate_register)) >> rng); // R11 R16
                acc_next = acc_reg;
                cnt_next = (cnt_reg != '0) ? cnt_reg - 32'h00000001 : cnt_reg; // R18
                if (!enabled) begin
                    acc_next = '0; // R12
                    cnt_next = '0;
                end else if (owr_tick) begin
                    if (acc_sum[ACC_W-1 +: 2] != 2'b00) begin
                        acc_next = ACC_W'(acc_sum - (ACC_W+1)'(1) * (49'h1 << (ACC_W-1))); // R22
                        // Overlapping pulse is dropped; host keeps width under period
                        if (cnt_reg == '0) begin
                            cnt_next = pulse_low_cycles; // R18 R20
                        end
                    end else begin
                        acc_next = acc_sum[ACC_W-1:0]; // R22
                    end
                end
            end

            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    acc_reg <= '0;
                    cnt_reg <= '0;
                end else begin
                    acc_reg <= acc_next;
                    cnt_reg <= cnt_next;
                end
            end

            assign gen_low[g] = (cnt_reg != '0);
        end
    endgenerate

    // Pin routing: any generator to any pin, push-pull or open-drain
    always_comb begin
        logic [SEL_W-1:0] mode;
        logic             low;
        logic             drive;
        mode = MODE_HIZ;
        low  = 1'b0;
        drive = 1'b0;
        for (int p = 0; p < NUM_GEN; p++) begin
            mode  = output_config_register[p*SEL_W +: SEL_W];
            drive = (mode >= MODE_GEN1) && (32'(mode - MODE_GEN1) < NUM_GEN); // R10 R15
            low   = drive ? gen_low[2'(mode - MODE_GEN1)] : 1'b0;
            if (!drive) begin
                pin_next[p] = 1'b0; // R12
                oe_next[p]  = 1'b0;
            end else if (output_config_register[OD_LSB + p]) begin
                pin_next[p] = 1'b0; // R13
                oe_next[p]  = low;
            end else begin
                pin_next[p] = ~low; // R13
                oe_next[p]  = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_reg <= '0;
            oe_reg  <= '0;
        end else begin
            pin_reg <= pin_next;
            oe_reg  <= oe_next;
        end
    end

    assign reg_rdata             = rdata_reg;
    assign total_channel_select  = sel_reg;
    assign auto_select_active    = region_reg;
    assign active_voltage        = vout_reg;
    assign digital_output_pin    = pin_reg;
    assign digital_output_pin_oe = oe_reg;

    // Checks
    logic [31:0] low_len;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_len <= '0;
        end else begin
            low_len <= gen_low[0] ? low_len + 32'h00000001 : '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence ln_tick_s;
        owr_tick && (meter_configuration_field == LINE_NEUTRAL_MODE);
    endsequence
    sequence auto_tick_s;
        ln_tick_s ##0 !channel_hold;
    endsequence

    hold_force_a: assert property (ln_tick_s ##0 channel_hold |=> sel_reg == $past(channel_force)) // R7
        else $error("held selection does not follow force bit");
    mode_gate_a: assert property (owr_tick && meter_configuration_field != LINE_NEUTRAL_MODE |=> !sel_reg) // R21
        else $error("selection active outside line-neutral mode");
    hyst_switch_a: assert property (auto_tick_s ##0 (in_region && switch_cond) |=> sel_reg != $past(sel_reg)) // R4
        else $error("channel did not switch past hysteresis");
    hyst_keep_a: assert property (auto_tick_s ##0 !(in_region && switch_cond) |=> $stable(sel_reg)) // R5
        else $error("channel changed without crossing hysteresis");
    light_load_a: assert property (auto_tick_s ##0 !in_region |=> $stable(sel_reg)) // R3
        else $error("channel changed below minimum amplitude");
    fixed_voltage_enable_path_a: assert property (fixed_voltage_enable ##1 fixed_voltage_enable |-> active_voltage == $past(fixed_voltage_reference)) // R8
        else $error("fixed voltage not applied");
    pin_hiz_a: assert property (output_config_register[SEL_W-1:0] == MODE_HIZ ##1 output_config_register[SEL_W-1:0] == MODE_HIZ |-> !digital_output_pin_oe[0]) // R12
        else $error("pin driven in high impedance mode");
    open_drain_a: assert property ( // R13
        output_config_register[OD_LSB + NUM_GEN - 1]
        && output_config_register[(NUM_GEN-1)*SEL_W +: SEL_W] == SEL_W'(NUM_GEN)
        |=> !digital_output_pin[NUM_GEN-1]
            && digital_output_pin_oe[NUM_GEN-1] == $past(gen_low[NUM_GEN-1]))
        else $error("open-drain pin drives high");
    pulse_len_a: assert property ($fell(gen_low[0]) && $stable(pulse_width_register) |-> $past(low_len) + 32'h00000001 == pulse_low_cycles) // R18
        else $error("pulse low time wrong");
    gen_off_a: assert property (!pulse_control_register[EN_LSB] |=> !gen_low[0]) // R12
        else $error("disabled generator still pulsing");
endmodule : tamper_pulse_core

// File: bench/pulse_counter_model.sv
// Purpose: meter-side pulse counter on the three digital outputs
// Assumes: pull-up on each line, so a released pin reads high
// Notes:   counts falling edges and the length of the last low phase
`timescale 1ns/1ns
module pulse_counter_model
    import tamper_pulse_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     clear,
    input  wire logic [NUM_GEN-1:0]       digital_output_pin,
    input  wire logic [NUM_GEN-1:0]       digital_output_pin_oe,
    output logic      [NUM_GEN-1:0][15:0] pulse_count,
    output logic      [NUM_GEN-1:0][15:0] last_low
);
    logic [NUM_GEN-1:0]       line;
    logic [NUM_GEN-1:0][15:0] low_run;
    // Open-drain and hi-Z both need the pull-up for the high level
    assign line = ~digital_output_pin_oe | digital_output_pin;
    always_ff @(posedge core_clk) begin
        for (int p = 0; p < NUM_GEN; p++) begin
            if (clear) begin
                pulse_count[p] <= '0;
                low_run[p]     <= '0;
            end else if (!line[p]) begin
                if (low_run[p] == 16'h0000) pulse_count[p] <= pulse_count[p] + 16'h0001;
                low_run[p] <= low_run[p] + 16'h0001;
            end else begin
                if (low_run[p] != 16'h0000) last_low[p] <= low_run[p];
                low_run[p] <= '0;
            end
        end
    end
endmodule : pulse_counter_model

// File: bench/tamper_select_energy_pulse_tb_top.sv
// Purpose: self-checking bench for channel selection, voltage mux and pulses
// Assumes: pulse base cut to 20 cycles; output word tick every other cycle
// Notes:   register reads are scored through a queue of expected words
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module tamper_select_energy_pulse_tb_top
    import tamper_pulse_pkg::*;
;
    logic                     core_clk = 1'b0;
    logic                     sys_rst  = 1'b1;
    reg_req_t                 reg_req  = '0;
    logic                     owr_tick = 1'b0;
    logic                     clear    = 1'b1;
    logic                     rd_seen  = 1'b0;
    logic [1:0][DATA_W-1:0]   avg      = '0;
    logic [1:0][DATA_W-1:0]   rms      = '0;
    logic [DATA_W-1:0]        vmeas    = '0;
    logic [15:0][DATA_W-1:0]  pres;
    logic [DATA_W-1:0]        reg_rdata, vact, exp_w;
    logic                     sel, region;
    logic [NUM_GEN-1:0]       pin, oe;
    logic [NUM_GEN-1:0][15:0] cnt, low;
    logic [DATA_W-1:0]        exp_q[$];
    int                       n_mismatch = 0;
    int                       total_checks = 0;
    int                       seed = 2100;
    int                       cyc = 0;

    always #4 core_clk = ~core_clk;

    tamper_pulse_core #(.NUM_RESULTS(16), .PULSE_BASE_CYC_P(20)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .owr_tick(owr_tick), .channel_power_average(avg), .channel_current_rms(rms),
        .measured_voltage_rms(vmeas), .power_result(pres), .total_channel_select(sel),
        .auto_select_active(region), .active_voltage(vact), .digital_output_pin(pin),
        .digital_output_pin_oe(oe));
    pulse_counter_model model_u (.core_clk(core_clk), .clear(clear), .digital_output_pin(pin),
        .digital_output_pin_oe(oe), .pulse_count(cnt), .last_low(low));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic settle();
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
    endtask : rd
    task automatic sel_step(input logic [5:0] cfg, input logic [DATA_W-1:0] a1, a2, r1, r2,
                            input logic es);
        wr(ADDR_METER_CFG, {18'h00000, cfg});
        @(posedge core_clk);
        avg      <= {a2, a1};
        rms      <= {r2, r1};
        owr_tick <= 1'b1;
        @(posedge core_clk);
        owr_tick <= 1'b0;
        settle();
        `CHK("channel select", es, sel)
    endtask : sel_step
    task automatic pulse_run(input logic [3:0] rng, input logic [15:0] e0, e1, e2);
        // Disable first so each run starts from an empty accumulator
        wr(ADDR_PULSE_CTRL, 24'h000975);
        wr(ADDR_PULSE_WID, {4'h0, rng, 16'h0000});
        wr(ADDR_PULSE_RATE, 24'h400000);
        clear <= 1'b1;
        wr(ADDR_PULSE_CTRL, 24'h007975);
        clear <= 1'b0;
        for (int i = 0; i < 4096; i++) begin
            @(posedge core_clk);
            owr_tick <= ~owr_tick;
        end
        repeat (40) @(posedge core_clk);
        @(negedge core_clk);
        `CHK("pulses pin0", e0, cnt[0])
        `CHK("pulses pin1", e1, cnt[1])
        `CHK("pulses pin2", e2, cnt[2])
        $display("test pulses range %0d finished", rng);
    endtask : pulse_run

    always @(posedge core_clk) begin
        if (rd_seen) begin
            exp_w = exp_q.pop_front();
            `CHK("read data", exp_w, reg_rdata)
        end
        rd_seen <= reg_req.rd;
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        for (int i = 0; i < 16; i++) pres[i] = DATA_W'($random(seed));
        pres[5] = 24'h400000;
        pres[7] = 24'h200000;
        pres[9] = 24'hC00000;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        `CHK("pins after reset", 6'h00, {oe, pin})
        rd(ADDR_OUTPUT_CFG, 24'h000000);
        rd(ADDR_PULSE_CTRL, 24'h000000);
        rd(ADDR_PULSE_WID, 24'h000001);
        rd(ADDR_FIXED_VOLTAGE_ENABLE_REF, 24'h5A827A);
        rd(ADDR_METER_CFG, 24'h000000);
        wr(4'hC, 24'hFFFFFF);
        rd(4'hC, 24'h000000);
        wr(ADDR_FIXED_VOLTAGE_ENABLE_REF, 24'h123456);
        rd(ADDR_FIXED_VOLTAGE_ENABLE_REF, 24'h123456);
        $display("test registers finished");
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            vmeas <= DATA_W'($random(seed));
            @(posedge core_clk);
            @(negedge core_clk);
            `CHK("measured voltage", vmeas, vact)
        end
        wr(ADDR_METER_CFG, 24'h000020);
        settle();
        `CHK("fixed voltage", 24'h123456, vact)
        $display("test voltage finished");
        wr(ADDR_SEL_MIN, 24'h100000);
        wr(ADDR_SEL_LEVEL, 24'h480000);
        sel_step(6'h00, 24'h200000, 24'h300000, '0, '0, 1'b1);
        `CHK("select region", 1'b1, region)
        sel_step(6'h00, 24'h320000, 24'h300000, '0, '0, 1'b1);
        sel_step(6'h00, 24'h380000, 24'h300000, '0, '0, 1'b0);
        sel_step(6'h00, 24'h080000, 24'h0F0000, '0, '0, 1'b0);
        `CHK("select region", 1'b0, region)
        sel_step(6'h04, 24'h380000, 24'h080000, 24'h100000, 24'h300000, 1'b1);
        sel_step(6'h00, 24'hC00000, 24'h380000, '0, '0, 1'b0);
        sel_step(6'h18, 24'h380000, 24'h080000, '0, '0, 1'b1);
        sel_step(6'h08, 24'h080000, 24'h380000, '0, '0, 1'b0);
        sel_step(6'h01, 24'h080000, 24'h380000, '0, '0, 1'b0);
        rd(ADDR_STATUS, 24'h000002);
        $display("test selection finished");
        wr(ADDR_OUTPUT_CFG, 24'h004321);
        settle();
        `CHK("idle pins", 6'h1B, {oe, pin})
        pulse_run(4'h6, 16'd4, 16'd2, 16'd4);
        `CHK("low time push-pull", 16'd20, low[0])
        `CHK("low time open-drain", 16'd20, low[2])
        pulse_run(4'h5, 16'd8, 16'd4, 16'd8);
        end_of_test();
    end
endmodule : tamper_select_energy_pulse_tb_top
